// ==== verilog/kefrc_pkg.sv ====
// Shared constants and types for the key-event readout and configuration block
package kefrc_pkg;
    // Register pointer values on the two-wire bus
    localparam logic [7:0] REG_KEY_QUEUE = 8'h00;
    localparam logic [7:0] REG_CONFIG = 8'h01;

    // Configuration register layout
    localparam int CFG_SLEEP_BIT = 7;
    localparam int CFG_IRQ_MODE_BIT = 5;
    localparam int CFG_REL_EN_BIT = 3;
    localparam int CFG_WAKE_EN_BIT = 1;
    localparam int CFG_TO_DIS_BIT = 0;
    localparam logic [7:0] CFG_RESET = 8'h0a;
    localparam logic [7:0] CFG_WRITE_MASK = 8'hab;

    // Queue entry layout: repeat flag, release flag, key number
    localparam int ENT_REPEAT_BIT = 7;
    localparam int ENT_REL_BIT = 6;
    localparam int ENT_WIDTH = 8;
    localparam int KEY_W = 6;

    // Key field codes of the read byte
    localparam logic [5:0] KEY_FIELD_ONES = 6'h3f;
    localparam logic [5:0] KEY_REPEAT_CODE = 6'h3e;
    localparam logic [5:0] KEY_HIGH_FIRST = 6'h3e;
    localparam logic [7:0] CODE_EMPTY = 8'h3f;
    localparam logic [7:0] CODE_OVERFLOW = 8'h7f;

    // Timing
    localparam int CLK_FREQ_MHZ = 100;
    localparam int BUS_TIMEOUT_US = 20000;
    localparam int BUS_TIMEOUT_CYCLES = BUS_TIMEOUT_US * CLK_FREQ_MHZ;

    // Queue depth and bus address; the address value is arbitrary
    localparam int QUEUE_DEPTH = 16;
    localparam logic [6:0] DEV_ADDR = 7'h38;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [2:0] {
        BUS_IDLE,
        BUS_ADDR,
        BUS_ADDR_ACK,
        BUS_WRITE,
        BUS_WRITE_ACK,
        BUS_READ,
        BUS_READ_ACK
    } kefrc_bus_state_t;
endpackage : kefrc_pkg

// ==== verilog/kefrc_evbuf.sv ====
// Two-entry event buffer with valid and ready on both sides
`timescale 1ns/1ps
module kefrc_evbuf #(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    logic [WIDTH-1:0] slot_reg [2];
    logic rd_ptr_reg;
    logic wr_ptr_reg;
    logic [1:0] cnt_reg;
    logic [1:0] cnt_next;
    logic ready_reg;
    wire push = in_valid_i & ready_reg;
    wire pop = out_valid_o & out_ready_i;

    assign cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
    assign in_ready_o = ready_reg;
    assign out_valid_o = cnt_reg != 2'h0;
    assign out_data_o = slot_reg[rd_ptr_reg];

    // Ready is registered so the scanner sees a flop, not a path through the queue
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_ptr_reg <= 1'b0;
            wr_ptr_reg <= 1'b0;
            cnt_reg <= 2'h0;
            ready_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            ready_reg <= cnt_next != 2'h2;
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            slot_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    buf_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cnt_reg != 2'h3) else $error("event buffer count out of range");
    buf_full_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (cnt_reg == 2'h2) |-> !in_ready_o) else $error("buffer ready while full");
endmodule : kefrc_evbuf

// ==== verilog/kefrc_evq.sv ====
// Key-event queue with count and sticky overflow flag
`timescale 1ns/1ps
module kefrc_evq #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 8,
    parameter int CW = $clog2(DEPTH + 1)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic push_i,
    input wire logic [WIDTH-1:0] push_data_i,
    input wire logic pop_i,
    input wire logic ovf_clr_i,
    output logic [WIDTH-1:0] head_o,
    output logic [CW-1:0] count_o,
    output logic empty_o,
    output logic ovf_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] rd_idx_reg;
    logic [AW-1:0] wr_idx_reg;
    logic [CW-1:0] count_reg;
    logic ovf_reg;
    wire full = count_reg == CW'(DEPTH);
    wire do_pop = pop_i & ~empty_o;
    wire do_push = push_i & ~full;

    assign empty_o = count_reg == '0;
    assign head_o = mem_reg[rd_idx_reg];
    assign count_o = count_reg;
    assign ovf_o = ovf_reg;

    function automatic logic [AW-1:0] kefrc_wrap(input logic [AW-1:0] idx);
        return (idx == AW'(DEPTH - 1)) ? '0 : idx + 1'b1;
    endfunction : kefrc_wrap

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_idx_reg <= '0;
            wr_idx_reg <= '0;
            count_reg <= '0;
            ovf_reg <= 1'b0;
        end else begin
            count_reg <= count_reg + CW'(do_push) - CW'(do_pop);
            if (do_push) begin
                wr_idx_reg <= kefrc_wrap(wr_idx_reg);
            end
            if (do_pop) begin
                rd_idx_reg <= kefrc_wrap(rd_idx_reg);
            end
            // A lost event in the clearing cycle keeps the flag set
            if (push_i && full) begin
                ovf_reg <= 1'b1;
            end else if (ovf_clr_i) begin
                ovf_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (do_push) begin
            mem_reg[wr_idx_reg] <= push_data_i;
        end
    end

    q_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
        count_reg <= CW'(DEPTH)) else $error("queue count above depth");
    q_ovf_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (push_i && full) |=> ovf_o && count_o == CW'(DEPTH))
        else $error("overflow not flagged on push while full");
endmodule : kefrc_evq

// ==== verilog/kefrc_top.sv ====
// Key-event queue read port and global configuration behind a two-wire slave
// Operation
// - Key number of a queue byte sits in bits 5 to 0.
// - Ordinary keys: bit 7 is 1 while more entries remain, else 0.
// - Bit 6 is 1 for a release event, 0 for a press.
// - Empty reads 0x3f; overflow reads 0x7f and host keeps reading.
// - Keys 62 and 63 always read with bit 7 set; host reads again.
// - Repeat entry reads key field 111110, bit 7 clear, bit 6 more-flag.
// - While PWM enable is high the sleep bit is frozen, scanning stays on.
// - Sleep bit: 0 shuts down, 1 operates; writes, autosleep, autowake change it.
// - Sleep bit reads back its current value at any time.
// - Interrupt mode 0 holds the key interrupt until the queue is empty.
// - Interrupt mode 1 releases the key interrupt on a host queue read.
`timescale 1ns/1ps
module kefrc_top #(
    parameter int QUEUE_DEPTH = kefrc_pkg::QUEUE_DEPTH,
    parameter int TIMEOUT_CYCLES = kefrc_pkg::BUS_TIMEOUT_CYCLES,
    parameter logic [6:0] DEV_ADDR = kefrc_pkg::DEV_ADDR
) (
    input wire logic SYS_CLK_I,
    input wire logic RESET_I,
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_N_O,
    input wire logic KEY_EVT_VALID_I,
    input wire logic [5:0] KEY_EVT_NUM_I,
    input wire logic KEY_EVT_RELEASE_I,
    input wire logic KEY_EVT_REPEAT_I,
    output logic KEY_EVT_READY_O,
    input wire logic AUTOSLEEP_I,
    input wire logic PWM_EN_I,
    output logic KEY_SCAN_EN_O,
    output logic KEY_EVENT_IRQ_N_O
);
    localparam int CW = $clog2(QUEUE_DEPTH + 1);
    localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
    localparam int EW = kefrc_pkg::ENT_WIDTH;

    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RESET_I);

    // Pin synchronisers; stage 0 feeds only stage 1
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic scl_reg;
    logic sda_reg;
    wire scl_s = scl_sync_reg[1];
    wire sda_s = sda_sync_reg[1];
    wire scl_rise = scl_s & ~scl_reg;
    wire scl_fall = ~scl_s & scl_reg;
    wire start_cond = scl_s & scl_reg & ~sda_s & sda_reg;
    wire stop_cond = scl_s & scl_reg & sda_s & ~sda_reg;

    kefrc_pkg::kefrc_bus_state_t state_reg;
    kefrc_pkg::kefrc_bus_state_t state_next;
    logic [3:0] bit_cnt_reg;
    logic [3:0] bit_cnt_next;
    logic [7:0] shreg_reg;
    logic [7:0] shreg_next;
    logic [7:0] ptr_reg;
    logic [7:0] ptr_next;
    logic rw_reg;
    logic rw_next;
    logic first_reg;
    logic first_next;
    logic sda_low_reg;
    logic sda_low_next;
    logic sda_out_reg;
    logic sda_oe_n_reg;
    logic wr_stb;
    logic rd_load;
    logic [TW-1:0] to_cnt_reg;

    logic [7:0] cfg_reg;
    logic [7:0] cfg_next;
    logic scan_en_reg;
    logic irq_pend_reg;
    logic irq_n_reg;

    logic [EW-1:0] evt_word;
    logic buf_in_valid;
    logic [EW-1:0] buf_data;
    logic buf_valid;
    logic q_ready;
    logic q_push;
    logic [EW-1:0] q_head;
    logic [CW-1:0] q_count;
    logic q_empty;
    logic q_ovf;

    // Bus timeout runs only while a transfer holds the clock low
    wire timeout_en = ~cfg_reg[kefrc_pkg::CFG_TO_DIS_BIT];
    wire to_counting = timeout_en & (state_reg != kefrc_pkg::BUS_IDLE) & ~scl_s;
    wire timeout_hit = to_counting & (to_cnt_reg == TW'(TIMEOUT_CYCLES - 1));

    function automatic logic [7:0] kefrc_encode(input logic empty, input logic ovf,
                                                input logic more, input logic [7:0] ent);
        logic rel;
        rel = ent[kefrc_pkg::ENT_REL_BIT];
        if (ovf) begin
            return kefrc_pkg::CODE_OVERFLOW;
        end
        if (empty) begin
            return kefrc_pkg::CODE_EMPTY;
        end
        if (ent[kefrc_pkg::ENT_REPEAT_BIT]) begin
            return {1'b0, more, kefrc_pkg::KEY_REPEAT_CODE};
        end
        if (ent[5:0] >= kefrc_pkg::KEY_HIGH_FIRST) begin
            return {1'b1, rel, ent[5:0]};
        end
        return {more, rel, ent[5:0]};
    endfunction : kefrc_encode

    wire q_more = q_count > CW'(1);
    wire [7:0] queue_code = kefrc_encode(q_empty, q_ovf, q_more, q_head);
    wire ptr_is_queue = ptr_reg == kefrc_pkg::REG_KEY_QUEUE;
    wire ptr_is_cfg = ptr_reg == kefrc_pkg::REG_CONFIG;
    wire [7:0] rd_byte = ptr_is_queue ? queue_code : (ptr_is_cfg ? cfg_reg : 8'h00);
    wire queue_read = rd_load & ptr_is_queue;
    wire q_pop = queue_read & ~q_empty & ~q_ovf;
    wire q_ovf_clr = queue_read & q_ovf;
    wire cfg_wr = wr_stb & ptr_is_cfg;

    always_comb begin
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg;
        shreg_next = shreg_reg;
        ptr_next = ptr_reg;
        rw_next = rw_reg;
        first_next = first_reg;
        sda_low_next = sda_low_reg;
        wr_stb = 1'b0;
        rd_load = 1'b0;
        if (stop_cond || timeout_hit) begin
            state_next = kefrc_pkg::BUS_IDLE;
            sda_low_next = 1'b0;
        end else if (start_cond) begin
            state_next = kefrc_pkg::BUS_ADDR;
            bit_cnt_next = 4'h0;
            sda_low_next = 1'b0;
        end else begin
            case (state_reg)
                kefrc_pkg::BUS_ADDR, kefrc_pkg::BUS_WRITE: begin
                    if (scl_rise && bit_cnt_reg != kefrc_pkg::BITS_PER_BYTE) begin
                        shreg_next = {shreg_reg[6:0], sda_s};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == kefrc_pkg::BITS_PER_BYTE) begin
                        if (state_reg == kefrc_pkg::BUS_WRITE) begin
                            if (first_reg) begin
                                ptr_next = shreg_reg;
                            end else begin
                                wr_stb = 1'b1;
                                ptr_next = ptr_reg + 8'h01;
                            end
                            first_next = 1'b0;
                            sda_low_next = 1'b1;
                            state_next = kefrc_pkg::BUS_WRITE_ACK;
                        end else if (shreg_reg[7:1] == DEV_ADDR) begin
                            rw_next = shreg_reg[0];
                            sda_low_next = 1'b1;
                            state_next = kefrc_pkg::BUS_ADDR_ACK;
                        end else begin
                            state_next = kefrc_pkg::BUS_IDLE;
                        end
                    end
                end
                kefrc_pkg::BUS_ADDR_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_next = 4'h0;
                        first_next = 1'b1;
                        sda_low_next = 1'b0;
                        if (rw_reg) begin
                            rd_load = 1'b1;
                            state_next = kefrc_pkg::BUS_READ;
                        end else begin
                            state_next = kefrc_pkg::BUS_WRITE;
                        end
                    end
                end
                kefrc_pkg::BUS_WRITE_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_next = 4'h0;
                        sda_low_next = 1'b0;
                        state_next = kefrc_pkg::BUS_WRITE;
                    end
                end
                kefrc_pkg::BUS_READ: begin
                    if (scl_rise) begin
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_reg == kefrc_pkg::BITS_PER_BYTE) begin
                            sda_low_next = 1'b0;
                            state_next = kefrc_pkg::BUS_READ_ACK;
                        end else begin
                            shreg_next = {shreg_reg[6:0], 1'b0};
                            sda_low_next = ~shreg_reg[6];
                        end
                    end
                end
                kefrc_pkg::BUS_READ_ACK: begin
                    if (scl_rise && sda_s) begin
                        state_next = kefrc_pkg::BUS_IDLE;
                    end else if (scl_fall) begin
                        rd_load = 1'b1;
                        bit_cnt_next = 4'h0;
                        state_next = kefrc_pkg::BUS_READ;
                    end
                end
                default: begin
                end
            endcase
        end
        // Queue reads keep the pointer so a burst drains the queue
        if (rd_load) begin
            shreg_next = rd_byte;
            sda_low_next = ~rd_byte[7];
            ptr_next = ptr_is_queue ? ptr_reg : ptr_reg + 8'h01;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], SCL_I};
            sda_sync_reg <= {sda_sync_reg[0], SDA_I};
            scl_reg <= scl_s;
            sda_reg <= sda_s;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            state_reg <= kefrc_pkg::BUS_IDLE;
            bit_cnt_reg <= 4'h0;
            shreg_reg <= 8'h00;
            ptr_reg <= kefrc_pkg::REG_KEY_QUEUE;
            rw_reg <= 1'b0;
            first_reg <= 1'b0;
            sda_low_reg <= 1'b0;
            sda_out_reg <= 1'b0;
            sda_oe_n_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            shreg_reg <= shreg_next;
            ptr_reg <= ptr_next;
            rw_reg <= rw_next;
            first_reg <= first_next;
            sda_low_reg <= sda_low_next;
            sda_out_reg <= 1'b0;
            sda_oe_n_reg <= ~sda_low_next;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I || !to_counting) begin
            to_cnt_reg <= '0;
        end else begin
            to_cnt_reg <= to_cnt_reg + TW'(1);
        end
    end

    // Configuration and sleep control
    wire [7:0] cfg_wr_val = shreg_reg & kefrc_pkg::CFG_WRITE_MASK;
    wire press_in = q_push & ~buf_data[kefrc_pkg::ENT_REL_BIT]
                    & ~buf_data[kefrc_pkg::ENT_REPEAT_BIT];
    wire wake = press_in & cfg_reg[kefrc_pkg::CFG_WAKE_EN_BIT]
                & ~cfg_reg[kefrc_pkg::CFG_SLEEP_BIT];
    // Host write outranks autowake, which outranks autosleep
    wire sleep_next = PWM_EN_I ? cfg_reg[kefrc_pkg::CFG_SLEEP_BIT] :
                      cfg_wr ? cfg_wr_val[kefrc_pkg::CFG_SLEEP_BIT] :
                      wake ? 1'b1 :
                      AUTOSLEEP_I ? 1'b0 : cfg_reg[kefrc_pkg::CFG_SLEEP_BIT];
    assign cfg_next = cfg_wr ? {sleep_next, cfg_wr_val[6:0]} : {sleep_next, cfg_reg[6:0]};

    // Event intake; releases are dropped here when reporting is off
    assign evt_word = {KEY_EVT_REPEAT_I, KEY_EVT_RELEASE_I, KEY_EVT_NUM_I};
    wire drop_rel = KEY_EVT_RELEASE_I & ~KEY_EVT_REPEAT_I
                    & ~cfg_reg[kefrc_pkg::CFG_REL_EN_BIT];
    assign buf_in_valid = KEY_EVT_VALID_I & ~drop_rel;
    // Queue stalls during a pop so the buffer really absorbs a burst
    assign q_ready = ~q_pop;
    assign q_push = buf_valid & q_ready;

    kefrc_evbuf #(
        .WIDTH(EW)
    ) u_evbuf (
        .clk_i(SYS_CLK_I),
        .rst_i(RESET_I),
        .in_data_i(evt_word),
        .in_valid_i(buf_in_valid),
        .in_ready_o(KEY_EVT_READY_O),
        .out_data_o(buf_data),
        .out_valid_o(buf_valid),
        .out_ready_i(q_ready)
    );

    kefrc_evq #(
        .DEPTH(QUEUE_DEPTH),
        .WIDTH(EW),
        .CW(CW)
    ) u_evq (
        .clk_i(SYS_CLK_I),
        .rst_i(RESET_I),
        .push_i(q_push),
        .push_data_i(buf_data),
        .pop_i(q_pop),
        .ovf_clr_i(q_ovf_clr),
        .head_o(q_head),
        .count_o(q_count),
        .empty_o(q_empty),
        .ovf_o(q_ovf)
    );

    wire irq_mode_rd = cfg_reg[kefrc_pkg::CFG_IRQ_MODE_BIT];
    wire irq_level = ~q_empty | q_ovf;

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            cfg_reg <= kefrc_pkg::CFG_RESET;
            scan_en_reg <= 1'b0;
            irq_pend_reg <= 1'b0;
            irq_n_reg <= 1'b1;
        end else begin
            cfg_reg <= cfg_next;
            scan_en_reg <= cfg_reg[kefrc_pkg::CFG_SLEEP_BIT] | PWM_EN_I;
            // New event wins over the read that clears
            irq_pend_reg <= q_push | (irq_pend_reg & ~queue_read);
            irq_n_reg <= ~(irq_mode_rd ? (irq_pend_reg & ~queue_read) : irq_level);
        end
    end

    assign SDA_O = sda_out_reg;
    // Separate flop so the pin enable has no inverter after the register
    assign SDA_OE_N_O = sda_oe_n_reg;
    assign KEY_SCAN_EN_O = scan_en_reg;
    assign KEY_EVENT_IRQ_N_O = irq_n_reg;

    key_field_a: assert property (q_pop && !q_head[kefrc_pkg::ENT_REPEAT_BIT]
        |=> shreg_reg[5:0] == $past(q_head[5:0])) else $error("key field wrong");
    more_flag_a: assert property (q_pop && !q_head[kefrc_pkg::ENT_REPEAT_BIT]
        && q_head[5:0] < kefrc_pkg::KEY_HIGH_FIRST |=> shreg_reg[7] == $past(q_count > CW'(1)))
        else $error("more flag wrong");
    release_flag_a: assert property (q_pop && !q_head[kefrc_pkg::ENT_REPEAT_BIT]
        |=> shreg_reg[6] == $past(q_head[kefrc_pkg::ENT_REL_BIT])) else $error("release flag");
    empty_code_a: assert property (queue_read && q_empty && !q_ovf
        |=> shreg_reg == kefrc_pkg::CODE_EMPTY) else $error("empty code wrong");
    ovf_code_a: assert property (queue_read && q_ovf
        && !(q_push && q_count == CW'(QUEUE_DEPTH))
        |=> shreg_reg == kefrc_pkg::CODE_OVERFLOW && !q_ovf) else $error("overflow code");
    high_key_a: assert property (q_pop && !q_head[kefrc_pkg::ENT_REPEAT_BIT]
        && q_head[5:0] >= kefrc_pkg::KEY_HIGH_FIRST |=> shreg_reg[7]) else $error("key 62/63");
    repeat_code_a: assert property (q_pop && q_head[kefrc_pkg::ENT_REPEAT_BIT]
        |=> shreg_reg == {1'b0, $past(q_more), kefrc_pkg::KEY_REPEAT_CODE})
        else $error("repeat code wrong");
    pwm_hold_a: assert property (PWM_EN_I |=> $stable(cfg_reg[kefrc_pkg::CFG_SLEEP_BIT])
        && KEY_SCAN_EN_O) else $error("sleep bit moved under pwm");
    sleep_write_a: assert property (cfg_wr && !PWM_EN_I
        |=> cfg_reg[kefrc_pkg::CFG_SLEEP_BIT] == $past(shreg_reg[7])) else $error("sleep write");
    sleep_read_a: assert property (rd_load && ptr_is_cfg
        |=> shreg_reg[7] == $past(cfg_reg[kefrc_pkg::CFG_SLEEP_BIT])) else $error("sleep read");
    irq_level_a: assert property (!irq_mode_rd && irq_level
        |=> !KEY_EVENT_IRQ_N_O) else $error("irq released before queue empty");
    irq_read_a: assert property (irq_mode_rd && queue_read && !q_push
        |=> KEY_EVENT_IRQ_N_O) else $error("irq not cleared by read");
    release_drop_a: assert property (buf_in_valid
        |-> !KEY_EVT_RELEASE_I || KEY_EVT_REPEAT_I || cfg_reg[kefrc_pkg::CFG_REL_EN_BIT])
        else $error("release queued while off");
    wake_a: assert property (wake && !PWM_EN_I && !cfg_wr
        |=> cfg_reg[kefrc_pkg::CFG_SLEEP_BIT]) else $error("keypress wake missed");
    timeout_off_a: assert property (cfg_reg[kefrc_pkg::CFG_TO_DIS_BIT]
        |-> !timeout_hit ##1 to_cnt_reg == '0) else $error("timeout while disabled");
    reserved_a: assert property ((cfg_reg & ~kefrc_pkg::CFG_WRITE_MASK) == 8'h00)
        else $error("reserved config bit set");
endmodule : kefrc_top

// ==== sim/kefrc_host.sv ====
// Two-wire host model; SDA open drain with a pull-up, SCL driven by the host alone
`timescale 1ns/1ps
module kefrc_host (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o = 1'b1,
    output logic sda_o = 1'b1
);
    task automatic ph(input logic s, input logic d, input int n);
        @(posedge clk_i);
        scl_o <= s;
        sda_o <= d;
        repeat (n) @(posedge clk_i);
    endtask : ph
    // Data moves with the clock low; a change while high is a start or stop
    task automatic cyc(input logic a, input logic b, output logic r);
        ph(1'b0, sda_o, 3);
        ph(1'b0, a, 7);
        ph(1'b1, a, 10);
        r = sda_i;
        ph(1'b1, b, 10);
    endtask : cyc
    task automatic xb(input logic [7:0] w, input logic a, output logic [7:0] r);
        logic k;
        for (int i = 7; i >= 0; i--) begin
            cyc(w[i], w[i], r[i]);
        end
        cyc(a, a, k);
    endtask : xb
endmodule : kefrc_host

// ==== sim/test_keypad_event_fifo_readout_config.sv ====
// Self-checking bench for the key-event readout and configuration block
`timescale 1ns/1ps
module test_keypad_event_fifo_readout_config;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic scl, hsda, sda_o, sda_oe_n, ev_v, ev_rel, ev_rep, ev_rdy, asleep, pwm, scan, irq_n;
    logic [5:0] ev_num = 6'h00;
    logic [7:0] r;
    int n_mismatch = 0;
    int total_checks = 0;
    wire logic sda = hsda & (sda_oe_n | sda_o);
    always #5 clk = ~clk;
    kefrc_top #(.TIMEOUT_CYCLES(50)) i_dut (.SYS_CLK_I(clk), .RESET_I(rst), .SCL_I(scl),
        .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_N_O(sda_oe_n), .KEY_EVT_VALID_I(ev_v),
        .KEY_EVT_NUM_I(ev_num), .KEY_EVT_RELEASE_I(ev_rel), .KEY_EVT_REPEAT_I(ev_rep),
        .KEY_EVT_READY_O(ev_rdy), .AUTOSLEEP_I(asleep), .PWM_EN_I(pwm),
        .KEY_SCAN_EN_O(scan), .KEY_EVENT_IRQ_N_O(irq_n));
    kefrc_host i_host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(hsda));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] p, input logic [7:0] d, input bit dat);
        logic k;
        i_host.cyc(1'b1, 1'b0, k);
        i_host.xb({kefrc_pkg::DEV_ADDR, 1'b0}, 1'b1, r);
        i_host.xb(p, 1'b1, r);
        if (dat) begin
            i_host.xb(d, 1'b1, r);
        end
        i_host.cyc(1'b0, 1'b1, k);
    endtask : wr
    // Pointer set, then a one-byte read ended by a NACK
    task automatic rdreg(input logic [7:0] p, input logic [7:0] e);
        logic k;
        wr(p, 8'h00, 1'b0);
        i_host.cyc(1'b1, 1'b0, k);
        i_host.xb({kefrc_pkg::DEV_ADDR, 1'b1}, 1'b1, r);
        i_host.xb(8'hff, 1'b1, r);
        i_host.cyc(1'b0, 1'b1, k);
        chk(r, e);
    endtask : rdreg
    // Clock held low after the address; a live timeout drops the rest of the write
    task automatic wr_stall(input logic [7:0] d);
        logic k;
        i_host.cyc(1'b1, 1'b0, k);
        i_host.xb({kefrc_pkg::DEV_ADDR, 1'b0}, 1'b1, r);
        i_host.ph(1'b0, 1'b1, 80);
        i_host.xb(8'h01, 1'b1, r);
        i_host.xb(d, 1'b1, r);
        i_host.cyc(1'b0, 1'b1, k);
    endtask : wr_stall
    task automatic ev(input logic [5:0] n, input logic rl, input logic rp);
        @(posedge clk);
        ev_v <= 1'b1;
        ev_num <= n;
        ev_rel <= rl;
        ev_rep <= rp;
        do @(posedge clk); while (ev_rdy !== 1'b1);
        ev_v <= 1'b0;
    endtask : ev
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end
    initial begin
        {ev_v, ev_rel, ev_rep, asleep, pwm} = '0;
        repeat (8) @(posedge clk);
        chk({6'h0, ev_rdy, irq_n}, 8'h01);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rdreg(8'h01, 8'h0a);
        wr(8'h01, 8'hff, 1'b1);
        rdreg(8'h01, 8'hab);
        chk({7'h0, scan}, 8'h01);
        wr(8'h01, 8'h2a, 1'b1);
        chk({7'h0, scan}, 8'h00);
        pwm <= 1'b1;
        wr(8'h01, 8'haa, 1'b1);
        rdreg(8'h01, 8'h2a);
        chk({7'h0, scan}, 8'h01);
        pwm <= 1'b0;
        wr(8'h01, 8'h8a, 1'b1);
        ev(6'd5, 1'b0, 1'b0);
        ev(6'd62, 1'b1, 1'b0);
        ev(6'd0, 1'b0, 1'b1);
        ev(6'd7, 1'b0, 1'b0);
        repeat (4) @(posedge clk);
        chk({7'h0, irq_n}, 8'h00);
        rdreg(8'h00, 8'h85);
        rdreg(8'h00, 8'hfe);
        rdreg(8'h00, 8'h7e);
        chk({7'h0, irq_n}, 8'h00);
        rdreg(8'h00, 8'h07);
        rdreg(8'h00, 8'h3f);
        chk({7'h0, irq_n}, 8'h01);
        wr(8'h01, 8'h82, 1'b1);
        ev(6'd9, 1'b1, 1'b0);
        rdreg(8'h00, 8'h3f);
        wr(8'h01, 8'haa, 1'b1);
        ev(6'd1, 1'b0, 1'b0);
        ev(6'd2, 1'b0, 1'b0);
        repeat (4) @(posedge clk);
        chk({7'h0, irq_n}, 8'h00);
        rdreg(8'h00, 8'h81);
        chk({7'h0, irq_n}, 8'h01);
        rdreg(8'h00, 8'h02);
        @(posedge clk);
        asleep <= 1'b1;
        @(posedge clk);
        asleep <= 1'b0;
        rdreg(8'h01, 8'h2a);
        ev(6'd3, 1'b0, 1'b0);
        rdreg(8'h01, 8'haa);
        rdreg(8'h00, 8'h03);
        for (int i = 0; i < 20; i++) begin
            ev(6'(i), 1'b0, 1'b0);
        end
        rdreg(8'h00, 8'h7f);
        for (int i = 0; i < 16; i++) begin
            rdreg(8'h00, {i != 15, 1'b0, 6'(i)});
        end
        wr_stall(8'h8b);
        rdreg(8'h01, 8'haa);
        wr(8'h01, 8'hab, 1'b1);
        wr_stall(8'h8b);
        rdreg(8'h01, 8'h8b);
        finish_test();
    end
endmodule : test_keypad_event_fifo_readout_config
